// file: verilog/activity_counter_pkg.sv
// Constants shared by the power activity counter bank
package activity_counter_pkg;
  // Counter width
  localparam int CNT_W = 32;
  // Threads per core
  localparam int THREADS = 4;
  // Prescaler width for fast or multi-event sources
  localparam int PRE_W = 3;
  // Event count width on a multi-event source (up to 7 events per cycle)
  localparam int EVT_W = 3;
  // Core counter indices
  localparam int C_CYCLES = 0;
  localparam int C_STALL_BUSY = 1;
  localparam int C_STALL_FIN = 2;
  localparam int C_MEM_EVT0 = 3;
  localparam int C_MEM_EVT1 = 4;
  localparam int C_DRAM = 5;
  localparam int CORE_CNT = 6;
  // Per-thread counter kinds
  localparam int T_RUN = 0;
  localparam int T_DISP = 1;
  localparam int T_COMPL = 2;
  localparam int T_DRAM = 3;
  localparam int THR_KINDS = 4;
  // Fabric counter indices
  localparam int F_OVERCOMMIT = 0;
  localparam int F_RETRY = 1;
  localparam int FAB_CNT = 2;
  // Total counters and select width
  localparam int TOTAL_CNT = CORE_CNT + THREADS * THR_KINDS + FAB_CNT;
  localparam int SEL_W = 5;
  // Reset value of all counters
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
  localparam logic [PRE_W-1:0] PRE_RESET = 3'h0;
  // Clock rate and minimum wrap time
  localparam longint CLK_HZ = 250_000_000;
  localparam longint WRAP_MIN_S = 1;
endpackage

// file: verilog/activity_counter_cell.sv
// One activity counter with an optional prescaler ahead of it
`timescale 1ns/1ps
`default_nettype none
module activity_counter_cell #(
  parameter int PRE_BITS = 0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Events this cycle
  input wire logic [activity_counter_pkg::EVT_W-1:0] events_i,
  // Counter value
  output logic [activity_counter_pkg::CNT_W-1:0] count_o
);
  import activity_counter_pkg::*;

  // Prescaler carries one extra bit to catch its overflow
  localparam int PW = PRE_BITS + 1;

  // Whole state of the cell
  typedef struct packed {
    logic [PW-1:0] pre; // Prescaler
    logic [CNT_W-1:0] cnt; // Counter
  } cell_type;

  cell_type state; // Registered state
  cell_type next_state; // Next state

  // Prescale events, then advance counter
  always_comb begin
    logic [PW:0] sum;
    sum = '0;
    next_state = state;
    if (PRE_BITS == 0) begin
      // Single-event source: one per event
      next_state.cnt = state.cnt + CNT_W'(events_i != '0);
    end else begin
      // Accumulate events; carry out advances the counter
      sum = {1'b0, state.pre} + (PW+1)'(events_i);
      next_state.pre = PW'(sum) & PW'((1 << PRE_BITS) - 1);
      next_state.cnt = state.cnt + CNT_W'(sum[PW:PRE_BITS] != '0);
    end
  end

  // Register state; free running with no enable
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      next_state_reset: begin
        state.pre <= '0;
        state.cnt <= CNT_RESET;
      end
    end else begin
      state <= next_state;
    end
  end

  assign count_o = state.cnt;
endmodule
`default_nettype wire

// file: verilog/power_activity_counters.sv
// Power activity counter bank with two read paths
`timescale 1ns/1ps
`default_nettype none
module power_activity_counters #(
  parameter int NTHREADS = activity_counter_pkg::THREADS,
  parameter int FAST_PRE_BITS = activity_counter_pkg::PRE_W
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // Core event strobes
  input wire logic STALL_BUSY_I,
  input wire logic STALL_FINISH_I,
  input wire logic MEM_EVT0_I,
  input wire logic MEM_EVT1_I,
  input wire logic CORE_DRAM_I,
  // Per-thread activity
  input wire logic [NTHREADS-1:0] RUN_LATCH_I,
  input wire logic [NTHREADS*activity_counter_pkg::EVT_W-1:0] DISPATCH_CNT_I,
  input wire logic [NTHREADS*activity_counter_pkg::EVT_W-1:0] COMPLETE_CNT_I,
  input wire logic [NTHREADS-1:0] THREAD_DRAM_I,
  // Fabric events
  input wire logic FAB_OVERCOMMIT_I,
  input wire logic FAB_RETRY_I,
  // Special purpose register read port
  input wire logic SPR_RD_I,
  input wire logic [activity_counter_pkg::SEL_W-1:0] SPR_SEL_I,
  output logic SPR_VALID_O,
  output logic [activity_counter_pkg::CNT_W-1:0] SPR_DATA_O,
  // Serial configuration access read port
  input wire logic SCFG_RD_I,
  input wire logic [activity_counter_pkg::SEL_W-1:0] SCFG_SEL_I,
  output logic SCFG_VALID_O,
  output logic [activity_counter_pkg::CNT_W-1:0] SCFG_DATA_O,
  output logic SCFG_ERR_O
);
  import activity_counter_pkg::*;

  // Counter count for this build
  localparam int NCNT = CORE_CNT + NTHREADS * THR_KINDS + FAB_CNT;
  localparam int FAB_BASE = CORE_CNT + NTHREADS * THR_KINDS;

  // Live counter values, one per counter
  logic [CNT_W-1:0] live [NCNT];
  // Event inputs per counter
  logic [EVT_W-1:0] evt [NCNT];

  // Whole registered state: both read answers
  typedef struct packed {
    logic spr_valid; // SPECIAL_PURPOSE_REGISTER answer strobe
    logic [CNT_W-1:0] spr_data; // SPECIAL_PURPOSE_REGISTER snapshot
    logic scfg_valid; // Serial answer strobe
    logic [CNT_W-1:0] scfg_data; // Serial snapshot
    logic scfg_err; // Serial unmapped select
  } rd_type;

  rd_type state; // Registered answers
  rd_type next_state; // Next answers

  // Core and fabric event mapping; no perf monitor input exists
  // Continuous assigns only, so every element has one driver kind
  assign evt[C_CYCLES] = EVT_W'(1);
  assign evt[C_STALL_BUSY] = EVT_W'(STALL_BUSY_I);
  assign evt[C_STALL_FIN] = EVT_W'(STALL_FINISH_I);
  assign evt[C_MEM_EVT0] = EVT_W'(MEM_EVT0_I);
  assign evt[C_MEM_EVT1] = EVT_W'(MEM_EVT1_I);
  assign evt[C_DRAM] = EVT_W'(CORE_DRAM_I);
  assign evt[FAB_BASE + F_OVERCOMMIT] = EVT_W'(FAB_OVERCOMMIT_I);
  assign evt[FAB_BASE + F_RETRY] = EVT_W'(FAB_RETRY_I);

  // Per-thread event mapping
  genvar t;
  generate
    for (t = 0; t < NTHREADS; t++) begin : g_thr
      localparam int B = CORE_CNT + t * THR_KINDS;
      assign evt[B + T_RUN] = EVT_W'(RUN_LATCH_I[t]);
      assign evt[B + T_DISP] = DISPATCH_CNT_I[t*EVT_W +: EVT_W];
      assign evt[B + T_COMPL] = COMPLETE_CNT_I[t*EVT_W +: EVT_W];
      assign evt[B + T_DRAM] = EVT_W'(THREAD_DRAM_I[t]);
    end
  endgenerate

  // One counter cell per counter; multi-event ones prescaled
  genvar c;
  generate
    for (c = 0; c < NCNT; c++) begin : g_cnt
      localparam bit FAST = (c >= CORE_CNT) && (c < FAB_BASE) &&
        ((((c - CORE_CNT) % THR_KINDS) == T_DISP) ||
         (((c - CORE_CNT) % THR_KINDS) == T_COMPL));
      activity_counter_cell #(
        .PRE_BITS(FAST ? FAST_PRE_BITS : 0)
      ) u_cell (
        .clk_i(CLK_SYS_I),
        .arst_n_i(ARST_N_I),
        .events_i(evt[c]),
        .count_o(live[c])
      );
    end
  endgenerate

  // Read decode: snapshot taken in one cycle, counters untouched
  always_comb begin
    next_state = state;
    next_state.spr_valid = SPR_RD_I;
    next_state.scfg_valid = SCFG_RD_I;
    next_state.scfg_err = 1'b0;
    if (SPR_RD_I) begin
      // Hypervisor path sees core and thread counters only
      if (int'(SPR_SEL_I) < FAB_BASE) begin
        next_state.spr_data = live[SPR_SEL_I];
      end else begin
        next_state.spr_data = CNT_RESET;
      end
    end
    if (SCFG_RD_I) begin
      // Firmware path sees all counters incl. fabric
      if (int'(SCFG_SEL_I) < NCNT) begin
        next_state.scfg_data = live[SCFG_SEL_I];
      end else begin
        next_state.scfg_data = CNT_RESET;
        next_state.scfg_err = 1'b1;
      end
    end
  end

  // Register read answers
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign SPR_VALID_O = state.spr_valid;
  assign SPR_DATA_O = state.spr_data;
  assign SCFG_VALID_O = state.scfg_valid;
  assign SCFG_DATA_O = state.scfg_data;
  assign SCFG_ERR_O = state.scfg_err;
endmodule
`default_nettype wire

// file: verification/power_activity_counters_chk.sv
// Read-port checker for the power activity counter bank
`timescale 1ns/1ps
`default_nettype none
module power_activity_counters_chk (
  // Clock, reset and both read ports
  input wire logic CLK_SYS_I, ARST_N_I, SPR_RD_I, SCFG_RD_I,
  input wire logic [4:0] SPR_SEL_I, SCFG_SEL_I,
  input wire logic SPR_VALID_O, SCFG_VALID_O, SCFG_ERR_O,
  input wire logic [31:0] SPR_DATA_O, SCFG_DATA_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);
  // Answers come exactly one cycle after the taken edge
  chk_spr_answer: assert property (SPR_RD_I |=> SPR_VALID_O)
    else $error("spr read not answered");
  chk_spr_quiet: assert property (!SPR_RD_I |=> !SPR_VALID_O)
    else $error("spr valid without read");
  chk_scfg_answer: assert property (SCFG_RD_I |=> SCFG_VALID_O)
    else $error("serial read not answered");
  // Out of range selects give zero, serial path flags it
  chk_scfg_refuse: assert property (SCFG_RD_I && SCFG_SEL_I > 23
    |=> SCFG_ERR_O && SCFG_DATA_O == 32'h0) else $error("serial refuse");
  chk_scfg_noerr: assert property (SCFG_RD_I && SCFG_SEL_I < 24
    |=> !SCFG_ERR_O) else $error("serial error on mapped index");
  chk_spr_refuse: assert property (SPR_RD_I && SPR_SEL_I > 21
    |=> SPR_DATA_O == 32'h0) else $error("spr refuse not zero");
  // Back to back cycle counter reads step by one
  chk_cycle_step: assert property (SPR_RD_I && SPR_SEL_I == 5'h0
    ##1 SPR_RD_I && SPR_SEL_I == 5'h0
    |=> SPR_DATA_O == $past(SPR_DATA_O) + 32'h1) else $error("no step");
  // Both paths see one coherent snapshot
  chk_paths_agree: assert property (SPR_RD_I && SCFG_RD_I
    && SPR_SEL_I == SCFG_SEL_I && SPR_SEL_I < 22
    |=> SPR_DATA_O == SCFG_DATA_O) else $error("paths disagree");
  // Read data holds between reads
  chk_data_hold: assert property (!SPR_RD_I |=> $stable(SPR_DATA_O))
    else $error("spr data moved without read");
  // Main scenarios
  cov_b2b: cover property (SPR_RD_I && SPR_SEL_I == 5'h0 ##1 SPR_RD_I);
  cov_err: cover property (SCFG_VALID_O && SCFG_ERR_O);
  cov_both: cover property (SPR_VALID_O && SCFG_VALID_O);
endmodule
bind power_activity_counters power_activity_counters_chk u_chk (
  .CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I), .SPR_RD_I(SPR_RD_I),
  .SCFG_RD_I(SCFG_RD_I), .SPR_SEL_I(SPR_SEL_I), .SCFG_SEL_I(SCFG_SEL_I),
  .SPR_VALID_O(SPR_VALID_O), .SCFG_VALID_O(SCFG_VALID_O),
  .SCFG_ERR_O(SCFG_ERR_O), .SPR_DATA_O(SPR_DATA_O),
  .SCFG_DATA_O(SCFG_DATA_O));
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the power activity counter bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import activity_counter_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, rd = 1'b0; // Clock, reset, read
  logic [4:0] sel = 5'h0, ev = 5'h0; // Select and core events
  logic [3:0] run = 4'h0, tdram = 4'h0; // Thread level events
  logic [11:0] disp = 12'h0, comp = 12'h0; // Thread event counts
  logic [1:0] fab = 2'h0; // Fabric events
  logic spr_v, scfg_v, scfg_err; // Answer flags
  logic [31:0] spr_d, scfg_d; // Answer data
  int num_errors = 0, n_checks = 0, cyc = 0;
  power_activity_counters u_power_activity_counters (
    .CLK_SYS_I(clk), .ARST_N_I(arst_n), .STALL_BUSY_I(ev[0]),
    .STALL_FINISH_I(ev[1]), .MEM_EVT0_I(ev[2]), .MEM_EVT1_I(ev[3]),
    .CORE_DRAM_I(ev[4]), .RUN_LATCH_I(run), .DISPATCH_CNT_I(disp),
    .COMPLETE_CNT_I(comp), .THREAD_DRAM_I(tdram),
    .FAB_OVERCOMMIT_I(fab[0]), .FAB_RETRY_I(fab[1]), .SPR_RD_I(rd),
    .SPR_SEL_I(sel), .SPR_VALID_O(spr_v), .SPR_DATA_O(spr_d),
    .SCFG_RD_I(rd), .SCFG_SEL_I(sel), .SCFG_VALID_O(scfg_v),
    .SCFG_DATA_O(scfg_d), .SCFG_ERR_O(scfg_err));
  // Clock and hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One read on both paths at once
  task automatic rd_one(input int s, output logic [31:0] d);
    @(posedge clk) rd <= 1'b1;
    sel <= 5'(s);
    @(posedge clk) rd <= 1'b0;
    #1 d = scfg_d;
    chk({30'h0, spr_v, scfg_v}, 32'h3);
    chk(spr_d, (s < 22) ? d : 32'h0);
    chk({31'h0, scfg_err}, {31'h0, s > 23});
  endtask
  // Sets the source feeding counter i
  task automatic drive_evt(input int i, input logic v);
    int t;
    int k;
    t = (i - 6) / 4;
    k = (i - 6) % 4;
    if (i < 6) ev[i-1] <= v;
    else if (i > 21) fab[i-22] <= v;
    else if (k == 0) run[t] <= v;
    else if (k == 3) tdram[t] <= v;
    else if (k == 1) disp[t*3+:3] <= {3{v}};
    else comp[t*3+:3] <= {3{v}};
  endtask
  // Free running cycle count between two reads
  task automatic t_cycles();
    logic [31:0] a, b;
    rd_one(0, a);
    chk(a, 32'h1);
    repeat (10) @(posedge clk);
    rd_one(0, b);
    chk(b - a, 32'd12);
  endtask
  // Reset in mid-run clears cycle and thread counters
  task automatic t_reset();
    logic [31:0] a;
    @(posedge clk) arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd_one(0, a);
    chk(a, 32'h1);
    rd_one(7, a);
    chk(a, 32'h0);
  endtask
  // Eight event cycles on every counter except the cycle counter, reads never clear
  task automatic t_events();
    logic [31:0] a, b;
    for (int i = 1; i < 24; i++) begin
      rd_one(i, a);
      @(posedge clk) drive_evt(i, 1'b1);
      repeat (8) @(posedge clk);
      drive_evt(i, 1'b0);
      rd_one(i, b);
      // Seven events a cycle pass an eight to one prescaler
      chk(b - a, (i > 5 && i < 22 && (i % 4 == 3 || i % 4 == 0)) ?
        32'd7 : 32'd8);
    end
  endtask
  // Unmapped selects and back to back reads
  task automatic t_refuse();
    logic [31:0] d;
    rd_one(24, d);
    chk(d, 32'h0);
    rd_one(31, d);
    @(posedge clk) rd <= 1'b1;
    sel <= 5'h0;
    repeat (3) @(posedge clk);
    rd <= 1'b0;
    #1 chk(spr_d, scfg_d);
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_cycles();
    t_events();
    t_refuse();
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
